// [rtl/frtc_cfg.svh]
// Register offsets, field positions and timing constants of the timer counter
`ifndef FRTC_CFG_SVH
`define FRTC_CFG_SVH
`define FRTC_ADDR_W        4
`define FRTC_OFF_CNT_HI    4'h0
`define FRTC_OFF_CNT_LO    4'h1
`define FRTC_OFF_ALT_HI    4'h2
`define FRTC_OFF_ALT_LO    4'h3
`define FRTC_OFF_STATUS    4'h4
`define FRTC_OFF_CTRL_ONE  4'h5
`define FRTC_OFF_CTRL_TWO  4'h6
`define FRTC_CNT_RESET     16'hFFFC
`define FRTC_CNT_MAX       16'hFFFF
`define FRTC_CNT_ZERO      16'h0000
`define FRTC_ST_OVF_BIT    5
`define FRTC_C1_OVIE_BIT   5
`define FRTC_C2_EDGE_BIT   0
`define FRTC_C2_CC_LSB     2
`define FRTC_DIV_W         3
`define FRTC_EXT_MIN_GAP   3'h4
`endif

// [rtl/frtc_pkg.sv]
// Types shared by the timer counter
package frtc_pkg;
    typedef enum logic [1:0] {
        FRTC_CLK_DIV2,
        FRTC_CLK_DIV4,
        FRTC_CLK_DIV8,
        FRTC_CLK_EXT
    } frtc_clk_sel_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } frtc_bus_req_t;

    typedef struct packed {
        logic       overflow_irq;
        logic       overflow_flag;
        logic [15:0] count;
    } frtc_status_t;
endpackage : frtc_pkg

// [rtl/frtc_timer.sv]
// Free-running 16-bit timer counter with buffered reads and overflow flag
`timescale 1ns/1ps
`default_nettype none
`include "frtc_cfg.svh"

// Overview of operation
// - Sixteen-bit counter advances once per timer tick, split in two bytes.
// - Tick is CPU clock over 2, 4, 8, or the external clock.
// - Counter resets to FFFC; that is its only reload value.
// - Writing either low byte reloads FFFC.
// - Main and alternate views read the same count.
// - High byte read latches low byte; next low read returns it.
// - Latched low byte frozen across repeated high reads until low read.
// - Low read outside a sequence returns the live low byte.
// - Overflow flag sets on wrap from FFFF to 0000.
// - Interrupt asserted when flag, enable set and global mask clear.
// - Flag clears after status read with flag set then main low access.
// - Alternate low byte accesses never clear the flag.
// - Wait state leaves the counter running.
// - Halt freezes the counter; interrupt wake resumes, reset restarts.
// - Unbonded timer input reads as one.
// - Two instances share nothing and stay in step after reset.
// - Both clock-select bits one pick external clock; edge bit chooses edge.
// - External edges synchronised; four CPU edges between active edges.
module frtc_timer #(
    parameter int  CNT_W       = 16,
    parameter bit  EXT_BONDED  = 1'b1
) (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire frtc_pkg::frtc_bus_req_t bus_req,
    output logic [7:0]                 rdata,
    input  wire logic                  cpu_halt,
    input  wire logic                  cpu_wait,
    input  wire logic                  global_irq_mask,
    input  wire logic                  ext_timer_clock_pin,
    output frtc_pkg::frtc_status_t     status
);

    // ------------------------------------------------------------
    // Control registers and clock select
    // ------------------------------------------------------------
    logic [7:0] timer_ctrl_one_reg;
    logic [7:0] timer_ctrl_two_reg;
    logic       overflow_irq_enable;
    logic       ext_clock_edge_select;
    frtc_pkg::frtc_clk_sel_t timer_clock_select;

    assign overflow_irq_enable   = timer_ctrl_one_reg[`FRTC_C1_OVIE_BIT];
    assign ext_clock_edge_select = timer_ctrl_two_reg[`FRTC_C2_EDGE_BIT];
    assign timer_clock_select    = frtc_pkg::frtc_clk_sel_t'(
        timer_ctrl_two_reg[`FRTC_C2_CC_LSB +: 2]);

    logic wr_hit_c1;
    logic wr_hit_c2;
    logic wr_cnt_lo;
    logic wr_alt_lo;
    logic rd_cnt_hi;
    logic rd_cnt_lo;
    logic rd_alt_hi;
    logic rd_alt_lo;
    logic rd_status;

    assign wr_hit_c1 = bus_req.wr && bus_req.addr == `FRTC_OFF_CTRL_ONE;
    assign wr_hit_c2 = bus_req.wr && bus_req.addr == `FRTC_OFF_CTRL_TWO;
    assign wr_cnt_lo = bus_req.wr && bus_req.addr == `FRTC_OFF_CNT_LO;
    assign wr_alt_lo = bus_req.wr && bus_req.addr == `FRTC_OFF_ALT_LO;
    assign rd_cnt_hi = bus_req.rd && bus_req.addr == `FRTC_OFF_CNT_HI;
    assign rd_cnt_lo = bus_req.rd && bus_req.addr == `FRTC_OFF_CNT_LO;
    assign rd_alt_hi = bus_req.rd && bus_req.addr == `FRTC_OFF_ALT_HI;
    assign rd_alt_lo = bus_req.rd && bus_req.addr == `FRTC_OFF_ALT_LO;
    assign rd_status = bus_req.rd && bus_req.addr == `FRTC_OFF_STATUS;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_ctrl_one_reg <= 8'h00;
        end else if (wr_hit_c1) begin
            timer_ctrl_one_reg <= bus_req.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_ctrl_two_reg <= 8'h00;
        end else if (wr_hit_c2) begin
            timer_ctrl_two_reg <= bus_req.wdata;
        end
    end

    // ------------------------------------------------------------
    // External clock synchroniser and edge detect
    // ------------------------------------------------------------
    logic ext_pin_seen;
    logic ext_sync1_reg;
    logic ext_sync2_reg;
    logic ext_prev_reg;
    logic ext_edge;

    assign ext_pin_seen = EXT_BONDED ? ext_timer_clock_pin : 1'b1;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_sync1_reg <= 1'b1;
            ext_sync2_reg <= 1'b1;
            ext_prev_reg  <= 1'b1;
        end else begin
            ext_sync1_reg <= ext_pin_seen;
            ext_sync2_reg <= ext_sync1_reg;
            ext_prev_reg  <= ext_sync2_reg;
        end
    end

    // Edge select one means rising, zero falling
    assign ext_edge = ext_clock_edge_select ?
        (ext_sync2_reg && !ext_prev_reg) :
        (!ext_sync2_reg && ext_prev_reg);

    // ------------------------------------------------------------
    // Prescaler and tick
    // ------------------------------------------------------------
    logic [`FRTC_DIV_W-1:0] div_reg;
    logic                   tick;
    logic                   run;

    assign run = !cpu_halt;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_reg <= '0;
        end else if (run) begin
            div_reg <= div_reg + 3'h1;
        end
    end

    always_comb begin
        case (timer_clock_select)
            frtc_pkg::FRTC_CLK_DIV2: tick = run && div_reg[0];
            frtc_pkg::FRTC_CLK_DIV4: tick = run && &div_reg[1:0];
            frtc_pkg::FRTC_CLK_DIV8: tick = run && &div_reg;
            frtc_pkg::FRTC_CLK_EXT:  tick = run && ext_edge;
            default:                 tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [CNT_W-1:0] count_reg;
    logic             wrap;

    assign wrap = tick && count_reg == `FRTC_CNT_MAX;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_reg <= `FRTC_CNT_RESET;
        end else if (wr_cnt_lo || wr_alt_lo) begin
            count_reg <= `FRTC_CNT_RESET;
        end else if (tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ------------------------------------------------------------
    // Buffered low byte for high-first reads
    // ------------------------------------------------------------
    logic [7:0] lo_buf_reg;
    logic       lo_held_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo_held_reg <= 1'b0;
            lo_buf_reg  <= 8'h00;
        end else if (rd_cnt_lo || rd_alt_lo) begin
            lo_held_reg <= 1'b0;
        end else if ((rd_cnt_hi || rd_alt_hi) && !lo_held_reg) begin
            lo_held_reg <= 1'b1;
            lo_buf_reg  <= count_reg[7:0];
        end
    end

    // ------------------------------------------------------------
    // Overflow flag with two-step clear
    // ------------------------------------------------------------
    logic overflow_flag_reg;
    logic clr_armed_reg;
    logic main_lo_access;

    assign main_lo_access = rd_cnt_lo || wr_cnt_lo;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clr_armed_reg <= 1'b0;
        end else if (rd_status && overflow_flag_reg) begin
            clr_armed_reg <= 1'b1;
        end else if (main_lo_access || !overflow_flag_reg) begin
            clr_armed_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            overflow_flag_reg <= 1'b0;
        end else if (wrap) begin
            overflow_flag_reg <= 1'b1;
        end else if (clr_armed_reg && main_lo_access) begin
            overflow_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read data and status outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata <= 8'h00;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `FRTC_OFF_CNT_HI,
                `FRTC_OFF_ALT_HI:   rdata <= count_reg[15:8];
                `FRTC_OFF_CNT_LO,
                `FRTC_OFF_ALT_LO:   rdata <= lo_held_reg ? lo_buf_reg
                                              : count_reg[7:0];
                `FRTC_OFF_STATUS:   rdata <= {2'b00, overflow_flag_reg,
                                              5'b00000};
                `FRTC_OFF_CTRL_ONE: rdata <= timer_ctrl_one_reg;
                `FRTC_OFF_CTRL_TWO: rdata <= timer_ctrl_two_reg;
                default:            rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    logic irq_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= overflow_flag_reg && overflow_irq_enable
                       && !global_irq_mask;
        end
    end

    assign status.overflow_irq  = irq_reg;
    assign status.overflow_flag = overflow_flag_reg;
    assign status.count         = count_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_RESET_LOAD: assert property (@(posedge clk) disable iff (rst)
        (wr_cnt_lo || wr_alt_lo) |=> count_reg == `FRTC_CNT_RESET)
        else $error("low byte write did not reload counter");

    AST_COUNT_STEP: assert property (@(posedge clk) disable iff (rst)
        (tick && !wr_cnt_lo && !wr_alt_lo)
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter did not advance on tick");

    AST_HOLD_HALT: assert property (@(posedge clk) disable iff (rst)
        (cpu_halt && !wr_cnt_lo && !wr_alt_lo) |=> $stable(count_reg))
        else $error("counter moved while halted");

    AST_DIV2_RATE: assert property (@(posedge clk) disable iff (rst)
        (timer_clock_select == frtc_pkg::FRTC_CLK_DIV2 && tick && !cpu_halt
         && !wr_hit_c2) |=> !tick)
        else $error("divide by two ticked twice in a row");

    AST_OVF_SET: assert property (@(posedge clk) disable iff (rst)
        wrap |=> overflow_flag_reg && count_reg == `FRTC_CNT_ZERO)
        else $error("overflow flag not set on wrap");

    AST_ALT_NO_CLR: assert property (@(posedge clk) disable iff (rst)
        (overflow_flag_reg && (rd_alt_lo || wr_alt_lo)) |=> overflow_flag_reg)
        else $error("alternate access cleared overflow flag");

    AST_TWO_STEP: assert property (@(posedge clk) disable iff (rst)
        (overflow_flag_reg && !clr_armed_reg) |=> overflow_flag_reg)
        else $error("overflow flag cleared without status read");

    AST_LO_BUF: assert property (@(posedge clk) disable iff (rst)
        (rd_cnt_hi && !lo_held_reg) ##1 (rd_cnt_lo && !rd_cnt_hi)
        |=> rdata == $past(count_reg[7:0], 2))
        else $error("buffered low byte mismatch");

    AST_IRQ: assert property (@(posedge clk) disable iff (rst)
        (overflow_flag_reg && overflow_irq_enable && !global_irq_mask)
        |=> irq_reg)
        else $error("interrupt not raised");

    AST_WAIT_RUN: assert property (@(posedge clk) disable iff (rst)
        (cpu_wait && !cpu_halt) |=> div_reg == $past(div_reg) + 3'h1)
        else $error("prescaler stopped in wait state");

    AST_HALT_DIV: assert property (@(posedge clk) disable iff (rst)
        cpu_halt |=> $stable(div_reg))
        else $error("prescaler moved while halted");

    AST_HALT_NO_TICK: assert property (@(posedge clk) disable iff (rst)
        cpu_halt |-> !tick)
        else $error("tick while halted");

    AST_DIV4_GAP: assert property (@(posedge clk) disable iff (rst)
        (timer_clock_select == frtc_pkg::FRTC_CLK_DIV4 && tick && !wr_hit_c2)
        |=> !tick)
        else $error("divide by four ticked twice in a row");

    AST_DIV8_GAP: assert property (@(posedge clk) disable iff (rst)
        (timer_clock_select == frtc_pkg::FRTC_CLK_DIV8 && tick && !wr_hit_c2)
        |=> !tick)
        else $error("divide by eight ticked twice in a row");

    AST_EXT_GAP: assert property (@(posedge clk) disable iff (rst)
        (timer_clock_select == frtc_pkg::FRTC_CLK_EXT && tick && !wr_hit_c2)
        |=> !tick)
        else $error("external edge counted twice");

    AST_OVF_ONLY_WRAP: assert property (@(posedge clk) disable iff (rst)
        (!overflow_flag_reg && !wrap) |=> !overflow_flag_reg)
        else $error("overflow flag set without wrap");

    AST_OVF_CLR: assert property (@(posedge clk) disable iff (rst)
        (clr_armed_reg && main_lo_access && !wrap) |=> !overflow_flag_reg)
        else $error("overflow flag not cleared by second step");

    AST_ARM_NEEDS_FLAG: assert property (@(posedge clk) disable iff (rst)
        $rose(clr_armed_reg) |-> $past(rd_status) && $past(overflow_flag_reg))
        else $error("clear armed without status read of set flag");

    AST_LO_HOLD: assert property (@(posedge clk) disable iff (rst)
        (lo_held_reg && !rd_cnt_lo && !rd_alt_lo)
        |=> lo_held_reg && $stable(lo_buf_reg))
        else $error("latched low byte changed before low read");

    AST_LO_LIVE: assert property (@(posedge clk) disable iff (rst)
        ((rd_cnt_lo || rd_alt_lo) && !lo_held_reg)
        |=> rdata == $past(count_reg[7:0]))
        else $error("low read outside sequence not live");

    AST_LO_HELD: assert property (@(posedge clk) disable iff (rst)
        ((rd_cnt_lo || rd_alt_lo) && lo_held_reg)
        |=> rdata == $past(lo_buf_reg))
        else $error("low read in sequence not buffered");

    AST_VIEW_SAME: assert property (@(posedge clk) disable iff (rst)
        (rd_cnt_hi || rd_alt_hi) |=> rdata == $past(count_reg[15:8]))
        else $error("high byte read mismatch");

    AST_IRQ_LOW: assert property (@(posedge clk) disable iff (rst)
        !(overflow_flag_reg && overflow_irq_enable && !global_irq_mask)
        |=> !irq_reg)
        else $error("interrupt raised without cause");

    AST_RDATA_IDLE: assert property (@(posedge clk) disable iff (rst)
        !bus_req.rd |=> rdata == 8'h00)
        else $error("read data not zero after idle cycle");

    AST_CNT_ONLY_TICK: assert property (@(posedge clk) disable iff (rst)
        (!tick && !wr_cnt_lo && !wr_alt_lo) |=> $stable(count_reg))
        else $error("counter moved without tick");

    AST_CTRL_TWO_WR: assert property (@(posedge clk) disable iff (rst)
        wr_hit_c2 |=> timer_ctrl_two_reg == $past(bus_req.wdata))
        else $error("control two write lost");

    AST_ONLY_RELOAD: assert property (@(posedge clk) disable iff (rst)
        (count_reg != $past(count_reg)
         && count_reg != $past(count_reg) + 16'h0001)
        |-> count_reg == `FRTC_CNT_RESET)
        else $error("counter loaded a value other than reset");

endmodule : frtc_timer
`default_nettype wire

// [dv/tb_top.sv]
// Self-checking testbench of the free-running timer counter
`timescale 1ns/1ps
`default_nettype none
`include "frtc_cfg.svh"

module tb_top;
    logic                    clk = 1'b0;
    logic                    rst = 1'b1;
    frtc_pkg::frtc_bus_req_t bus_req = '0;
    logic [7:0]              rdata;
    logic                    cpu_halt = 1'b1;
    logic                    cpu_wait = 1'b0;
    logic                    global_irq_mask = 1'b1;
    logic                    ext_timer_clock_pin = 1'b0;
    frtc_pkg::frtc_status_t  status;
    logic [7:0]              exq[$];
    logic                    rd_d = 1'b0;
    logic [15:0]             cnt_exp = `FRTC_CNT_RESET;
    logic [31:0]             seed = 32'h334b6eb5;
    logic [7:0]              d;
    int                      fail_count = 0;
    int                      checks = 0;
    int                      n;

    always #20 clk = ~clk;

    frtc_timer frtc_timer_i (
        .clk                 (clk),
        .rst                 (rst),
        .bus_req             (bus_req),
        .rdata               (rdata),
        .cpu_halt            (cpu_halt),
        .cpu_wait            (cpu_wait),
        .global_irq_mask     (global_irq_mask),
        .ext_timer_clock_pin (ext_timer_clock_pin),
        .status              (status)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] xr();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xr

    task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    // One bus cycle; a read notes its expected data
    task automatic acc(logic [3:0] a, logic [7:0] wd, logic w, logic [7:0] e);
        @(posedge clk);
        bus_req <= '{addr: a, wdata: wd, wr: w, rd: !w};
        if (!w) exq.push_back(e);
        @(posedge clk);
        bus_req.wr <= 1'b0;
        bus_req.rd <= 1'b0;
    endtask : acc

    // Release halt for exactly k edges, then freeze again
    task automatic run(int k);
        @(posedge clk);
        cpu_halt <= 1'b0;
        cyc(k);
        cpu_halt <= 1'b1;
        cyc(3);
    endtask : run

    task automatic finish_test();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------
    // Read data monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        rd_d <= bus_req.rd;
        if (rd_d) chk("rdata", {8'h00, rdata}, {8'h00, exq.pop_front()});
    end

    initial begin
        cyc(30000);
        fail_count++;
        finish_test();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        cyc(16);
        rst <= 1'b0;
        cyc(2);
        chk("count", status.count, cnt_exp);
        cyc(20);
        chk("count", status.count, cnt_exp);
        $display("test reset done");

        acc(4'h5, 8'h20, 1'b1, 8'h00);
        run(8);
        cnt_exp += 16'h0004;
        chk("count", status.count, cnt_exp);
        chk("flag", status.overflow_flag, 16'h0001);
        chk("irq", status.overflow_irq, 16'h0000);
        global_irq_mask <= 1'b0;
        cyc(3);
        chk("irq", status.overflow_irq, 16'h0001);
        acc(4'h1, 8'h00, 1'b0, 8'h00);
        acc(4'h3, 8'h00, 1'b0, 8'h00);
        chk("flag", status.overflow_flag, 16'h0001);
        acc(4'h4, 8'h00, 1'b0, 8'h20);
        acc(4'h3, 8'h00, 1'b0, 8'h00);
        chk("flag", status.overflow_flag, 16'h0001);
        acc(4'h4, 8'h00, 1'b0, 8'h20);
        acc(4'h1, 8'h00, 1'b0, 8'h00);
        cyc(2);
        chk("flag", status.overflow_flag, 16'h0000);
        chk("irq", status.overflow_irq, 16'h0000);
        $display("test overflow done");

        acc(4'h0, 8'h00, 1'b0, 8'h00);
        n = int'(xr() % 200) + 3;
        run(2 * n);
        cnt_exp += 16'(n);
        acc(4'h2, 8'h00, 1'b0, cnt_exp[15:8]);
        acc(4'h1, 8'h00, 1'b0, 8'h00);
        acc(4'h3, 8'h00, 1'b0, cnt_exp[7:0]);
        for (int v = 0; v < 2; v++) begin
            acc(4'(2 * v), 8'h00, 1'b0, cnt_exp[15:8]);
            acc(4'(2 * v + 1), 8'h00, 1'b0, cnt_exp[7:0]);
        end
        $display("test read sequence done");

        d = 8'(xr());
        acc(4'h0, d, 1'b1, 8'h00);
        acc(4'hF, 8'h00, 1'b0, 8'h00);
        chk("count", status.count, cnt_exp);
        acc(4'h1, d, 1'b1, 8'h00);
        cnt_exp = `FRTC_CNT_RESET;
        cyc(1);
        chk("count", status.count, cnt_exp);
        run(10);
        acc(4'h3, d, 1'b1, 8'h00);
        cyc(1);
        chk("count", status.count, cnt_exp);
        chk("flag", status.overflow_flag, 16'h0001);
        acc(4'h4, 8'h00, 1'b0, 8'h20);
        acc(4'h1, d, 1'b1, 8'h00);
        cyc(2);
        chk("flag", status.overflow_flag, 16'h0000);
        $display("test writes done");

        for (int s = 1; s < 3; s++) begin
            acc(4'h6, 8'(s << 2), 1'b1, 8'h00);
            n = int'(xr() % 20) + 1;
            run(n * (2 << s));
            cnt_exp += 16'(n);
            chk("count", status.count, cnt_exp);
        end
        $display("test prescaler done");

        cpu_wait <= 1'b1;
        for (int e = 1; e >= 0; e--) begin
            acc(4'h6, 8'h0C | 8'(e), 1'b1, 8'h00);
            n = int'(xr() % 6) + 1;
            cpu_halt <= 1'b0;
            repeat (n) begin
                ext_timer_clock_pin <= 1'b1;
                cyc(8);
                ext_timer_clock_pin <= 1'b0;
                cyc(8);
            end
            cpu_halt <= 1'b1;
            cyc(6);
            cnt_exp += 16'(n);
            chk("count", status.count, cnt_exp);
        end
        $display("test external clock done");

        rst <= 1'b1;
        cyc(2);
        rst <= 1'b0;
        cyc(2);
        chk("count", status.count, `FRTC_CNT_RESET);
        chk("flag", status.overflow_flag, 16'h0000);
        acc(4'h6, 8'h00, 1'b0, 8'h00);
        $display("test reset wake done");
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
